// >>> hdl/tks_map.vh
`ifndef TKS_MAP_VH
`define TKS_MAP_VH
// Register offsets.
`define TKS_OFS_MAIN 16'ha018
`define TKS_OFS_TIME 16'ha019
`define TKS_OFS_CFGC 16'ha01a
`define TKS_OFS_CFGD 16'ha01b
`define TKS_OFS_HDTYL 16'ha01c
`define TKS_OFS_HDTYH 16'ha01d
`define TKS_OFS_LDTYL 16'ha01e
`define TKS_OFS_LDTYH 16'ha01f
`define TKS_OFS_BASEL 16'ha028
`define TKS_OFS_BASEH 16'ha029
`define TKS_OFS_THDL 16'ha02a
`define TKS_OFS_THDH 16'ha02b
// Main control fields.
`define TKS_MAIN_EN 7
`define TKS_MAIN_CS_HI 6
`define TKS_MAIN_CS_LO 4
`define TKS_MAIN_SHIELD 3
`define TKS_MAIN_IEN 2
`define TKS_MAIN_LPM 1
`define TKS_MAIN_AUTO 0
// Timing setup fields.
`define TKS_TIME_RPT_HI 7
`define TKS_TIME_RPT_LO 6
`define TKS_TIME_INI_HI 5
`define TKS_TIME_INI_LO 4
`define TKS_TIME_AST_HI 3
`define TKS_TIME_AST_LO 2
`define TKS_TIME_LF_HI 1
`define TKS_TIME_LF_LO 0
// Status and control register D fields.
`define TKS_D_ASTEN 4
`define TKS_D_PRND 3
`define TKS_D_LOW_FREQ_NOISE_FILTER 2
`define TKS_D_IF 1
`define TKS_D_START 0
// Register C fields.
`define TKS_C_THRESHOLD_RELATIVE_SELECT 1
`define TKS_C_BASEINI 2
// Reset value of every register.
`define TKS_RST8 8'h00
// Timing counts in conversion clock periods; the skip count is in comparator edges.
`define TKS_INI_UNIT 4
`define TKS_AST_UNIT 256
`define TKS_LF_UNIT 8
`define TKS_SKIP_EDGES 4
`endif

// >>> hdl/tks_touch_key_sequencer.v
`timescale 1ns/10ps
// What this block does
// R1: Enable bit low disables sensing, returns the sequencer to idle and clears the duty counters and flags.
// R2: Conversion clock is system clock /2,4,6,8,10,16,32 or slow oscillator /2.
// R3: Software picks slow oscillator /2 for auto detect wakeup from sleep.
// R4: Shield enable bit turns on the guard buffer output while the enable bit is set.
// R5: With irq enable, interrupt when a sequence including repeats finishes.
// R6: With irq enable and auto mode, interrupt and wakeup on threshold exceeded.
// R7: Every touch interrupt also sets the touch interrupt flag.
// R8: Low power bit puts the key comparator in ultra low power mode.
// R9: Auto mode compares duty count against threshold value, raises events if higher.
// R10: In normal mode, writing start bit 1 begins a sequence.
// R11: Repeat field: one, four, eight or sixteen conversions per sequence.
// R12: Settling delay of (field+1)*4 conversion clocks before counting.
// R13: Auto start delay inserts (field+1)*256 conversion clocks at sequence start.
// R14: Filter off at 00, else ignore comparator level held longer than field*8, in auto mode only with register C bit 0 set.
// R15: Cycle count advances while noise is ignored.
// R16: Discard first comparator edges, then accumulate high and low time.
// R17: Duty counters keep accumulating across repeats of one sequence.
// R18: Integration cap equalized to near reference before and after a sequence.
// R19: Each conversion alternates charge and discharge phases, one conversion clock each, charge first.
// R20: Optional pseudo-random randomizing of charge and discharge timing.
// R21: Baseline register keeps a slow moving average of the duty count.
// R22: Start bit self-clears at completion; busy reads 1 while running.
// R23: Each conversion lasts 1024 to 65536 cycles by 3-bit field, ending exactly.
// R24: Threshold select: threshold alone, or threshold plus baseline.
// R25: Baseline averaging length is 32, 64, 128 or 256 sequences.
// R26: Clock division uses enable pulses; slow oscillator is synchronised first.
`include "tks_map.vh"
module tks_touch_key_sequencer #(
	parameter CW = 17
) (
	input wire clk_i,
	input wire reset_i,
	input wire [15:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	input wire slow_osc_i,
	input wire key_cmp_i,
	output reg sense_enable_o,
	output reg guard_buffer_enable_o,
	output reg comparator_low_power_o,
	output reg equalize_o,
	output reg charge_phase_o,
	output reg irq_o,
	output reg wakeup_o
);
	localparam ST_IDLE = 3'h0;
	localparam ST_DELAY = 3'h1;
	localparam ST_SETTLE = 3'h2;
	localparam ST_CONV = 3'h3;
	localparam ST_DONE = 3'h4;

	reg [7:0] main_q, time_q, cfgc_q;
	reg [4:0] ctld_q;
	reg low_freq_noise_filter_q, irqf_q, busy_q;
	reg [15:0] hdty_q, ldty_q, base_q, thd_q;
	reg [2:0] state_q;
	reg [5:0] div_q;
	reg [2:0] slow_oscillator_q;
	reg tick_q;
	reg [CW-1:0] cyc_q;
	reg [10:0] dly_q;
	reg [4:0] rpt_q;
	reg [2:0] edge_q;
	reg [1:0] cmp_q;
	reg cmp_prev_q;
	reg [4:0] run_q;
	reg [15:0] lfsr_q;
	reg base_init_q;
	reg auto_prev_q;

	wire en = main_q[`TKS_MAIN_EN];
	wire auto = main_q[`TKS_MAIN_AUTO];
	wire [2:0] cs = main_q[`TKS_MAIN_CS_HI:`TKS_MAIN_CS_LO];
	wire [1:0] repeat_count = time_q[`TKS_TIME_RPT_HI:`TKS_TIME_RPT_LO];
	wire [1:0] settling_delay = time_q[`TKS_TIME_INI_HI:`TKS_TIME_INI_LO];
	wire [1:0] ast = time_q[`TKS_TIME_AST_HI:`TKS_TIME_AST_LO];
	wire [1:0] lf = time_q[`TKS_TIME_LF_HI:`TKS_TIME_LF_LO];
	wire cmp = cmp_q[1];

	// Divider terminal count per select code: the divide ratio minus one, one tick per period.
	reg [5:0] div_end;
	always @* begin
		case (cs)
			3'h0: div_end = 6'h01; // R2
			3'h1: div_end = 6'h03;
			3'h2: div_end = 6'h05;
			3'h3: div_end = 6'h07;
			3'h4: div_end = 6'h09;
			3'h5: div_end = 6'h0f;
			3'h6: div_end = 6'h1f;
			default: div_end = 6'h01;
		endcase
	end

	// Conversion length in conversion clocks.
	reg [CW-1:0] cyc_end;
	always @* begin
		case (cfgc_q[4:2])
			3'h0: cyc_end = 17'd1024; // R23
			3'h1: cyc_end = 17'd2048;
			3'h2: cyc_end = 17'd4096;
			3'h3: cyc_end = 17'd8192;
			3'h4: cyc_end = 17'd12288;
			3'h5: cyc_end = 17'd16384;
			3'h6: cyc_end = 17'd32768;
			default: cyc_end = 17'd65536;
		endcase
	end

	// Number of conversions in one sequence.
	reg [4:0] rpt_end;
	always @* begin
		case (repeat_count)
			2'h0: rpt_end = 5'd1; // R11
			2'h1: rpt_end = 5'd4;
			2'h2: rpt_end = 5'd8;
			default: rpt_end = 5'd16;
		endcase
	end

	// Threshold alone or relative to the baseline.
	wire [16:0] thr = cfgc_q[`TKS_C_THRESHOLD_RELATIVE_SELECT] ? ({1'b0, thd_q} + {1'b0, base_q}) : {1'b0, thd_q}; // R24
	wire hit = {1'b0, ldty_q} > thr; // R9

	// Filter limit; a run longer than this is treated as noise.
	wire [4:0] lf_lim = {lf, 3'h0}; // R14
	wire noisy = (lf != 2'h0) && (run_q >= lf_lim);
	wire stuck = noisy && (!auto || cfgc_q[0]);

	// Pseudo-random dither skips a tick now and then to break up timing.
	wire dither = ctld_q[`TKS_D_PRND] && lfsr_q[0] && lfsr_q[5]; // R20

	// Delay loads; the products are cut to the delay counter width on purpose.
	wire [31:0] ast_len = ({30'h0, ast} + 32'h1) * `TKS_AST_UNIT;
	wire [31:0] ini_len = ({30'h0, settling_delay} + 32'h1) * `TKS_INI_UNIT;

	wire reg_wr = wr_i;
	wire wr_d = reg_wr && (addr_i == `TKS_OFS_CFGD);
	wire start_req = (wr_d && wdata_i[`TKS_D_START] && !auto) // R10
		|| (auto && !auto_prev_q);
	wire seq_end = (state_q == ST_CONV) && tick_q && (cyc_q == cyc_end - 1'b1)
		&& (rpt_q == rpt_end - 1'b1);
	wire evt_done = seq_end && main_q[`TKS_MAIN_IEN]; // R5
	wire evt_auto = seq_end && auto && hit && main_q[`TKS_MAIN_IEN]; // R6

	// Register writes; the software view of hardware flags obeys set-over-clear.
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			main_q <= `TKS_RST8;
			time_q <= `TKS_RST8;
			cfgc_q <= `TKS_RST8;
			ctld_q <= 5'h00;
			thd_q <= 16'h0000;
		end else begin
			if (reg_wr && addr_i == `TKS_OFS_MAIN)
				main_q <= wdata_i;
			if (reg_wr && addr_i == `TKS_OFS_TIME)
				time_q <= wdata_i;
			if (reg_wr && addr_i == `TKS_OFS_CFGC)
				cfgc_q <= wdata_i;
			if (reg_wr && addr_i == `TKS_OFS_THDL)
				thd_q[7:0] <= wdata_i;
			if (reg_wr && addr_i == `TKS_OFS_THDH)
				thd_q[15:8] <= wdata_i;
			if (wr_d)
				ctld_q <= {wdata_i[`TKS_D_ASTEN], wdata_i[`TKS_D_PRND], 3'h0};
		end
	end

	// Conversion clock enable, slow oscillator synchroniser and edge pick.
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			div_q <= 6'h00;
			slow_oscillator_q <= 3'h0;
			tick_q <= 1'b0;
		end else begin
			slow_oscillator_q <= {slow_oscillator_q[1:0], slow_osc_i}; // R26
			if (!en) begin
				div_q <= 6'h00; // R1
				tick_q <= 1'b0;
			end else if (cs == 3'h7) begin
				if (slow_oscillator_q[1] && !slow_oscillator_q[2]) begin
					div_q <= {5'h00, !div_q[0]};
					tick_q <= div_q[0] && !dither; // R2
				end else
					tick_q <= 1'b0;
			end else if (div_q >= div_end) begin
				div_q <= 6'h00;
				tick_q <= !dither; // R26
			end else begin
				div_q <= div_q + 6'h01;
				tick_q <= 1'b0;
			end
		end
	end

	// Sequencer, duty counting, noise filter, flags and baseline.
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= ST_IDLE;
			busy_q <= 1'b0;
			cyc_q <= {CW{1'b0}};
			dly_q <= 11'h000;
			rpt_q <= 5'h00;
			edge_q <= 3'h0;
			cmp_q <= 2'h0;
			cmp_prev_q <= 1'b0;
			run_q <= 5'h00;
			hdty_q <= 16'h0000;
			ldty_q <= 16'h0000;
			base_q <= 16'h0000;
			base_init_q <= 1'b0;
			low_freq_noise_filter_q <= 1'b0;
			irqf_q <= 1'b0;
			lfsr_q <= 16'hace1;
			auto_prev_q <= 1'b0;
		end else if (!en) begin
			state_q <= ST_IDLE; // R1
			busy_q <= 1'b0;
			hdty_q <= 16'h0000;
			ldty_q <= 16'h0000;
			low_freq_noise_filter_q <= 1'b0;
			irqf_q <= 1'b0;
			auto_prev_q <= 1'b0;
			run_q <= 5'h00;
			if (reg_wr && addr_i == `TKS_OFS_BASEL)
				base_q[7:0] <= wdata_i;
			if (reg_wr && addr_i == `TKS_OFS_BASEH)
				base_q[15:8] <= wdata_i;
		end else begin
			cmp_q <= {cmp_q[0], key_cmp_i};
			auto_prev_q <= auto;
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
			// Flags: hardware set wins over a software clear in the same cycle.
			if (evt_done || evt_auto)
				irqf_q <= 1'b1; // R7
			else if (wr_d && !wdata_i[`TKS_D_IF])
				irqf_q <= 1'b0;
			if (state_q == ST_CONV && tick_q && noisy && run_q == lf_lim)
				low_freq_noise_filter_q <= 1'b1;
			else if (wr_d && !wdata_i[`TKS_D_LOW_FREQ_NOISE_FILTER])
				low_freq_noise_filter_q <= 1'b0;
			if (reg_wr && addr_i == `TKS_OFS_BASEL)
				base_q[7:0] <= wdata_i;
			if (reg_wr && addr_i == `TKS_OFS_BASEH)
				base_q[15:8] <= wdata_i;
			if (!auto)
				base_init_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (start_req) begin
						busy_q <= 1'b1; // R22
						hdty_q <= 16'h0000;
						ldty_q <= 16'h0000;
						rpt_q <= 5'h00;
						dly_q <= (auto && ctld_q[`TKS_D_ASTEN]) ? ast_len[10:0] : ini_len[10:0];
						state_q <= (auto && ctld_q[`TKS_D_ASTEN]) ? ST_DELAY : ST_SETTLE; // R13
					end
				end
				ST_DELAY: begin
					if (tick_q) begin
						if (dly_q == 11'h001) begin
							state_q <= ST_SETTLE;
							dly_q <= ini_len[10:0];
						end else
							dly_q <= dly_q - 11'h001;
					end
				end
				ST_SETTLE: begin
					// Counting starts after exactly the settling window; edges are skipped later.
					if (tick_q) begin
						dly_q <= dly_q - 11'h001; // R12
						if (dly_q == 11'h001) begin
							state_q <= ST_CONV;
							cyc_q <= {CW{1'b0}};
							edge_q <= 3'h0;
							run_q <= 5'h00;
						end
					end
				end
				ST_CONV: begin
					if (tick_q) begin
						cyc_q <= cyc_q + 1'b1; // R15
						cmp_prev_q <= cmp;
						if (cmp != cmp_prev_q)
							run_q <= 5'h00;
						else if (run_q != 5'h1f)
							run_q <= run_q + 5'h01;
						if (cmp != cmp_prev_q && edge_q != `TKS_SKIP_EDGES)
							edge_q <= edge_q + 3'h1; // R16
						if (edge_q == `TKS_SKIP_EDGES && !stuck) begin
							if (cmp)
								hdty_q <= hdty_q + 16'h0001; // R17
							else
								ldty_q <= ldty_q + 16'h0001;
						end
						if (cyc_q == cyc_end - 1'b1) begin
							cyc_q <= {CW{1'b0}};
							edge_q <= 3'h0;
							if (rpt_q == rpt_end - 1'b1)
								state_q <= ST_DONE;
							else
								rpt_q <= rpt_q + 5'h01;
						end
					end
				end
				ST_DONE: begin
					busy_q <= 1'b0; // R22
					state_q <= ST_IDLE;
					// Moving average: base += (duty - base) / length.
					if (auto && cfgc_q[`TKS_C_BASEINI] && !base_init_q) begin
						base_q <= ldty_q;
						base_init_q <= 1'b1;
					end else begin
						base_q <= base_q + (ldty_q >> (5 + cfgc_q[7:6]))
							- (base_q >> (5 + cfgc_q[7:6])); // R21 R25
					end
					auto_prev_q <= 1'b0;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Pins, events and read data all leave from flip-flops.
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sense_enable_o <= 1'b0;
			guard_buffer_enable_o <= 1'b0;
			comparator_low_power_o <= 1'b0;
			equalize_o <= 1'b1;
			charge_phase_o <= 1'b0;
			irq_o <= 1'b0;
			wakeup_o <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			sense_enable_o <= en; // R1
			guard_buffer_enable_o <= en && main_q[`TKS_MAIN_SHIELD]; // R4
			comparator_low_power_o <= main_q[`TKS_MAIN_LPM]; // R8
			equalize_o <= state_q != ST_CONV; // R18
			charge_phase_o <= (state_q == ST_CONV) && !cyc_q[0]; // R19
			irq_o <= en && (evt_done || evt_auto);
			wakeup_o <= en && evt_auto; // R6
			rdata_o <= 8'h00;
			if (rd_i) begin
				case (addr_i)
					`TKS_OFS_MAIN: rdata_o <= main_q;
					`TKS_OFS_TIME: rdata_o <= time_q;
					`TKS_OFS_CFGC: rdata_o <= {cfgc_q[7:3], 1'b0, cfgc_q[1:0]};
					`TKS_OFS_CFGD: rdata_o <= {3'h0, ctld_q[4:3], low_freq_noise_filter_q, irqf_q, busy_q};
					`TKS_OFS_HDTYL: rdata_o <= hdty_q[7:0];
					`TKS_OFS_HDTYH: rdata_o <= hdty_q[15:8];
					`TKS_OFS_LDTYL: rdata_o <= ldty_q[7:0];
					`TKS_OFS_LDTYH: rdata_o <= ldty_q[15:8];
					`TKS_OFS_BASEL: rdata_o <= base_q[7:0];
					`TKS_OFS_BASEH: rdata_o <= base_q[15:8];
					`TKS_OFS_THDL: rdata_o <= thd_q[7:0];
					`TKS_OFS_THDH: rdata_o <= thd_q[15:8];
					default: rdata_o <= 8'h00;
				endcase
			end
		end
	end
endmodule // tks_touch_key_sequencer

// >>> testbench/tks_seq_asserts.sv
`timescale 1ns/10ps
// Watches the register port and the front-end controls of the sequencer.
module tks_seq_asserts #(
	parameter CW = 17
) (
	input wire clk_i,
	input wire reset_i,
	input wire [15:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire sense_enable_o,
	input wire guard_buffer_enable_o,
	input wire comparator_low_power_o,
	input wire equalize_o,
	input wire charge_phase_o,
	input wire irq_o,
	input wire wakeup_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Writes to the main control byte drive the static front-end controls.
	wire main_wr = wr_i && addr_i == 16'ha018;
	chk_en_follows: assert property (main_wr |=> ##1 sense_enable_o == $past(wdata_i[7], 2))
		else $error("enable output does not follow the written bit");
	chk_off_quiet: assert property (!sense_enable_o && !$past(sense_enable_o) |->
		equalize_o && !irq_o && !charge_phase_o) else $error("activity while disabled");
	chk_guard_pair: assert property (main_wr |=> ##1
		guard_buffer_enable_o == ($past(wdata_i[7], 2) && $past(wdata_i[3], 2)))
		else $error("guard buffer enable wrong");
	chk_lpm_follows: assert property (main_wr |=> ##1
		comparator_low_power_o == $past(wdata_i[1], 2)) else $error("low power output wrong");
	chk_irq_pulse: assert property (irq_o |=> !irq_o)
		else $error("interrupt longer than one cycle");
	chk_wake_irq: assert property (wakeup_o |-> irq_o)
		else $error("wakeup without interrupt");
	chk_charge_conv: assert property (charge_phase_o |-> !equalize_o)
		else $error("charging while equalized");
	chk_phase_alt: assert property ($rose(charge_phase_o) |-> ##[1:80] !charge_phase_o)
		else $error("charge phase never gives way to discharge");
	cover property (irq_o);
	cover property (wakeup_o);
	cover property ($rose(charge_phase_o));
endmodule // tks_seq_asserts

bind tks_touch_key_sequencer tks_seq_asserts #(.CW(CW)) chk_u (.clk_i(clk_i),
	.reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.sense_enable_o(sense_enable_o), .guard_buffer_enable_o(guard_buffer_enable_o),
	.comparator_low_power_o(comparator_low_power_o), .equalize_o(equalize_o),
	.charge_phase_o(charge_phase_o), .irq_o(irq_o), .wakeup_o(wakeup_o));

// >>> testbench/tks_key_frontend.sv
`timescale 1ns/10ps
// Behavioural key front end: the comparator follows the charge phase after a lag.
module tks_key_frontend #(
	parameter SLOW_HALF = 200,
	parameter LAG = 1
) (
	input wire clk_i,
	input wire sense_enable_i,
	input wire charge_phase_i,
	input wire stuck_i,
	output reg key_cmp_o,
	output reg slow_osc_o
);
	reg [3:0] lag_q = 4'h0;
	// The slow oscillator runs free from time zero, in fixed phase with the system clock.
	initial begin
		slow_osc_o = 1'b0;
		key_cmp_o = 1'b0;
	end
	always #(SLOW_HALF) slow_osc_o = ~slow_osc_o;
	// An idle comparator chatters, so a stale level is never mistaken for data.
	always @(posedge clk_i) begin
		lag_q <= {lag_q[2:0], charge_phase_i};
		if (!sense_enable_i)
			key_cmp_o <= ~key_cmp_o;
		else if (stuck_i)
			key_cmp_o <= 1'b1;
		else
			key_cmp_o <= lag_q[LAG];
	end
endmodule // tks_key_frontend

// >>> testbench/tks_touch_key_sequencer_test.sv
`timescale 1ns/10ps
// Register-level test of the sequencer against the behavioural front end.
module tks_touch_key_sequencer_test;
	reg clk_i = 1'b0;
	reg reset_i = 1'b1;
	reg [15:0] addr_i = 16'h0000;
	reg [7:0] wdata_i = 8'h00;
	reg wr_i = 1'b0;
	reg rd_i = 1'b0;
	reg stuck = 1'b0;
	reg wake = 1'b0;
	reg [7:0] d, b0, b1, b2, b3;
	wire [7:0] rdata_o;
	wire slow_osc_i, key_cmp_i, sense_enable_o, guard_buffer_enable_o;
	wire comparator_low_power_o, equalize_o, charge_phase_o, irq_o, wakeup_o;
	integer miscompares = 0;
	integer num_checks = 0;
	integer i, n, sum, dv;
	// The system clock runs at 10 MHz.
	always #50 clk_i = ~clk_i;
	tks_touch_key_sequencer dut_u (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.slow_osc_i(slow_osc_i), .key_cmp_i(key_cmp_i), .sense_enable_o(sense_enable_o),
		.guard_buffer_enable_o(guard_buffer_enable_o),
		.comparator_low_power_o(comparator_low_power_o), .equalize_o(equalize_o),
		.charge_phase_o(charge_phase_o), .irq_o(irq_o), .wakeup_o(wakeup_o));
	tks_key_frontend fe_u (.clk_i(clk_i), .sense_enable_i(sense_enable_o),
		.charge_phase_i(charge_phase_o), .stuck_i(stuck), .key_cmp_o(key_cmp_i),
		.slow_osc_o(slow_osc_i));
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
			end
		end
	endtask
	task wr(input [15:0] a, input [7:0] v);
		begin
			@(posedge clk_i);
			wr_i <= 1'b1;
			addr_i <= a;
			wdata_i <= v;
			@(posedge clk_i);
			wr_i <= 1'b0;
		end
	endtask
	// Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
	task rd(input [15:0] a, output [7:0] v);
		begin
			@(posedge clk_i);
			rd_i <= 1'b1;
			addr_i <= a;
			@(posedge clk_i);
			rd_i <= 1'b0;
			@(negedge clk_i);
			v = rdata_o;
		end
	endtask
	task rdc(input [15:0] a, input [7:0] e);
		begin
			rd(a, d);
			check($sformatf("reg %h", a), d, e);
		end
	endtask
	task duty;
		begin
			rd(16'ha01c, b0);
			rd(16'ha01d, b1);
			rd(16'ha01e, b2);
			rd(16'ha01f, b3);
			sum = {b1, b0} + {b3, b2};
		end
	endtask
	// Starts a sequence, jams the comparator high if asked, and times the interrupt.
	// The span allows a few divided periods for synchroniser and alignment slack.
	task seq(input [15:0] a, input [7:0] v, input integer jam, input integer units);
		begin
			wr(a, v);
			n = 0;
			while (irq_o !== 1'b1 && n < 40000) begin
				@(negedge clk_i);
				n = n + 1;
				if (n == jam)
					stuck = 1'b1;
				if (n == 20)
					rdc(16'ha01b, 8'h01);
			end
			wake = wakeup_o;
			stuck = 1'b0;
			check("span", n > (units - 4) * dv - 16 && n < (units + 4) * dv + 16, 1'b1);
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", num_checks, miscompares);
			if (miscompares == 0 && num_checks > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// A hang past the expected run length ends the test as a failure.
	initial begin
		#(115000 * 100);
		miscompares = miscompares + 1;
		finish_test;
	end
	// Main sequence of scenarios.
	initial begin
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		wr(16'ha01c, 8'hff);
		for (i = 0; i < 13; i = i + 1)
			rdc(i < 8 ? 16'ha018 + i : 16'ha020 + i, 8'h00);
		wr(16'ha018, 8'h8a);
		repeat (2) @(negedge clk_i);
		check("sense", sense_enable_o, 1'b1);
		check("guard", guard_buffer_enable_o, 1'b1);
		check("lowpower", comparator_low_power_o, 1'b1);
		rdc(16'ha018, 8'h8a);
		wr(16'ha01b, 8'h18);
		rdc(16'ha01b, 8'h18);
		wr(16'ha01b, 8'h00);
		wr(16'ha018, 8'h0a);
		repeat (2) @(negedge clk_i);
		check("guard off", guard_buffer_enable_o, 1'b0);
		// Each system clock code stretches a bare sequence by its own divisor.
		for (i = 0; i < 7; i = i + 1) begin
			dv = (i < 5) ? 2 * i + 2 : (i == 5 ? 16 : 32);
			wr(16'ha018, {1'b1, i[2:0], 4'h4});
			seq(16'ha01b, 8'h01, 0, 1028);
			rdc(16'ha01b, 8'h02);
			wr(16'ha01b, 8'h00);
		end
		// Four repeats with the longest settling keep accumulating duty time.
		dv = 2;
		wr(16'ha019, 8'h70);
		wr(16'ha018, 8'h84);
		seq(16'ha01b, 8'h01, 0, 4112);
		duty;
		check("repeat sum", sum > 4000 && sum <= 4096, 1'b1);
		rdc(16'ha01b, 8'h02);
		wr(16'ha01b, 8'h00);
		// A comparator stuck high is ignored by the filter while the count runs on.
		wr(16'ha019, 8'h01);
		seq(16'ha01b, 8'h01, 200, 1028);
		duty;
		check("noise sum", sum < 600, 1'b1);
		rdc(16'ha01b, 8'h06);
		wr(16'ha01b, 8'h00);
		// Auto detect on the slow oscillator with a zero threshold must wake.
		dv = 8;
		wr(16'ha019, 8'h00);
		seq(16'ha018, 8'hf7, 0, 1028);
		check("wakeup", wake, 1'b1);
		wr(16'ha018, 8'h00);
		rdc(16'ha01b, 8'h00);
		rdc(16'ha01e, 8'h00);
		finish_test;
	end
endmodule // tks_touch_key_sequencer_test
